// [design/link_bit_shift.sv]
/*
 * Serial data shifter clocked by the bus clock pin itself.
 * Assumes the reader samples o_byte only after it has seen the rising bus
 * clock edge through its own synchroniser, when the byte is stable.
 */
`timescale 1ns/1ns
module link_bit_shift (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic [7:0] o_byte
);
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;

    // msb first; pure data path, no control state to reset
    always_comb begin
        shift_nxt = {shift_r[6:0], i_sda};
    end

    always_ff @(posedge i_scl) begin
        shift_r <= shift_nxt;
    end

    assign o_byte = shift_r;
endmodule

// [design/sync_bits.sv]
/*
 * Two-stage synchroniser for a vector of unrelated pin levels.
 * Assumes each bit changes slowly compared with i_clk.
 */
`timescale 1ns/1ns
module sync_bits #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) $error("sync_bits: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// [design/top_irq_regs.sv]
/*
 * Top-level identity, interrupt-mask, interrupt-flag and live-status
 * registers, reached over a two-wire serial slave.
 * Assumes comparator and pin inputs are asynchronous, source interrupt
 * summaries come from logic on i_clk, and the bus clock pin also clocks
 * the bit shifter.
 */
// Summary of operation
// - the lsb of the address byte selects direction, 0 write and 1 read.
// - the slave answers at address pair cc/cd and at pair 90/91.
// - power-on class registers return to default while supply is below power-on level.
// - general class registers return to default on lockout, shutdown or manual reset low.
// - source mask holds charger, top, flash and backlight bits, all set after reset.
// - the lower die-hot flag sets when die temperature passes the lower limit.
// - the upper die-hot flag sets when die temperature passes the upper limit.
// - bit 3 flags a low supply event; the flag register resets to zero and clears on read.
// - top mask bits 0, 1 and 3 mask their events and reset to one.
// - status bit 2 shows the raw manual reset pin level.
// - status bit 3 is one while supply sits above the low threshold.
`timescale 1ns/1ns
`include "top_irq_cfg.svh"
module top_irq_regs
    import top_irq_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5a,  // arbitrary value
    parameter logic [7:0] REV_CODE = 8'h03  // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic i_manual_reset_n,
    input wire logic i_die_over_lower,
    input wire logic i_die_over_upper,
    input wire logic i_supply_above_threshold,
    input wire logic i_supply_below_por,
    input wire logic i_undervoltage_lockout,
    input wire logic i_chip_on,
    input wire logic i_charger_irq,
    input wire logic i_flash_irq,
    input wire logic i_backlight_irq,
    output logic o_irq_n
);
    // ****************************************************************
    // pin synchronisers and edges
    // ****************************************************************
    localparam logic [8:0] PIN_RST = 9'h127;
    logic [8:0] pins_s;
    logic [8:0] prev_r;
    logic [8:0] prev_nxt;
    logic [8:0] rise;
    logic [8:0] fall;
    logic [7:0] shift_byte;
    logic scl_s, sda_s, mrst_s, lower_s, upper_s, above_s, por_s, lockout_s, on_s;

    sync_bits #(.WIDTH(9), .RST_VAL(PIN_RST)) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async({i_chip_on, i_undervoltage_lockout, i_supply_below_por,
                  i_supply_above_threshold, i_die_over_upper, i_die_over_lower,
                  i_manual_reset_n, i_sda, i_scl}),
        .o_sync(pins_s)
    );

    // bits are shifted on the bus clock; the fsm reads them after the edge
    link_bit_shift u_shift (
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_byte(shift_byte)
    );

    assign {on_s, lockout_s, por_s, above_s, upper_s, lower_s, mrst_s, sda_s, scl_s} = pins_s;
    assign rise = pins_s & ~prev_r;
    assign fall = ~pins_s & prev_r;

    // previous levels for edge detection
    always_comb begin
        prev_nxt = pins_s;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            prev_r <= PIN_RST;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // ****************************************************************
    // reset classes
    // ****************************************************************
    logic por_rst;
    logic gen_rst;
    assign por_rst = !i_rstn || por_s;
    // on-to-off is a single pulse, the other causes hold while present
    assign gen_rst = por_rst || lockout_s || !mrst_s || fall[8];

    // ****************************************************************
    // serial slave
    // ****************************************************************
    link_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic sel_r, sel_nxt;
    logic ack_r, ack_nxt;
    logic txm_r, txm_nxt;
    logic oe_n_r, oe_n_nxt;
    logic rd_stb, wr_stb;
    logic start, stop, scl_rise, scl_fall, hit_main, hit_bl;
    logic [7:0] src_r, tmask_r, flags_r, stat_r;

    assign start = scl_s && prev_r[0] && fall[1];
    assign stop = scl_s && prev_r[0] && rise[1];
    assign scl_rise = rise[0];
    assign scl_fall = fall[0];
    assign hit_main = shift_byte[7:1] == 7'(`ADDR_MAIN_WR >> 1);
    assign hit_bl = shift_byte[7:1] == 7'(`ADDR_BACKLIGHT_WR >> 1);

    // read data; the backlight address has no registers in this group
    function automatic logic [7:0] rd_mux(input logic main, input logic [7:0] ofs,
                                          input logic [7:0] src, input logic [7:0] flg,
                                          input logic [7:0] msk, input logic [7:0] st);
        logic [7:0] v;
        v = 8'h00;
        if (main) begin
            unique case (ofs)
                `OFS_CHIP_IDENTITY: v = ID_CODE;
                `OFS_CHIP_REVISION: v = REV_CODE;
                `OFS_SOURCE_IRQ_MASK: v = src;
                `OFS_TOP_IRQ_FLAGS: v = flg;
                `OFS_TOP_IRQ_MASK: v = msk;
                `OFS_TOP_LIVE_STATUS: v = st;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // byte and ack sequencing; data changes only after a falling bus clock
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ptr_nxt = ptr_r;
        tx_nxt = tx_r;
        sel_nxt = sel_r;
        ack_nxt = ack_r;
        txm_nxt = txm_r;
        oe_n_nxt = oe_n_r;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        if (start || stop) begin
            state_nxt = start ? ST_ADDR : ST_IDLE;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            txm_nxt = 1'b0;
            oe_n_nxt = 1'b1;
        end else if (state_r != ST_IDLE && scl_rise) begin
            if (cnt_r == `LAST_DATA_BIT) begin
                cnt_nxt = `ACK_BIT;
                unique case (state_r)
                    ST_ADDR: begin
                        if (hit_main || hit_bl) begin
                            ack_nxt = 1'b1;
                            sel_nxt = hit_main;
                            state_nxt = shift_byte[0] ? ST_RDATA : ST_REG;
                        end else begin
                            state_nxt = ST_SKIP;
                        end
                    end
                    ST_REG: begin
                        ptr_nxt = shift_byte;
                        ack_nxt = 1'b1;
                        state_nxt = ST_WDATA;
                    end
                    ST_WDATA: begin
                        wr_stb = 1'b1;
                        ack_nxt = 1'b1;
                        ptr_nxt = ptr_r + 8'h01;
                    end
                    ST_RDATA, ST_SKIP, ST_IDLE: begin
                    end
                endcase
            end else if (cnt_r == `ACK_BIT) begin
                cnt_nxt = 4'h0;
                ack_nxt = 1'b0;
                if (state_r == ST_RDATA) begin
                    if (txm_r && sda_s) begin  // master refused more data
                        txm_nxt = 1'b0;
                        state_nxt = ST_SKIP;
                    end else begin
                        tx_nxt = rd_mux(sel_r, ptr_r, src_r, flags_r, tmask_r, stat_r);
                        rd_stb = 1'b1;
                        txm_nxt = 1'b1;
                        ptr_nxt = ptr_r + 8'h01;
                    end
                end
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end else if (state_r != ST_IDLE && scl_fall) begin
            if (cnt_r == `ACK_BIT) begin
                oe_n_nxt = !ack_r;
            end else if (txm_r) begin
                oe_n_nxt = tx_r[3'(`LAST_DATA_BIT - cnt_r)];
            end else begin
                oe_n_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            ptr_r <= 8'h00;
            tx_r <= 8'h00;
            sel_r <= 1'b0;
            ack_r <= 1'b0;
            txm_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ptr_r <= ptr_nxt;
            tx_r <= tx_nxt;
            sel_r <= sel_nxt;
            ack_r <= ack_nxt;
            txm_r <= txm_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    // ****************************************************************
    // register file and interrupt output
    // ****************************************************************
    logic [7:0] src_nxt, tmask_nxt, flags_nxt, stat_nxt, set_vec;
    logic irq_n_r, irq_n_nxt, pending;

    // comparator edges set flags; a level that stays high does not re-set
    assign set_vec = {4'h0, fall[5], 1'b0, rise[4], rise[3]};
    assign pending = (|(flags_r & ~tmask_r & `TOP_FLAG_USED)
                      && !src_r[`BIT_TOP_SOURCE_MASK])
                     || (i_charger_irq && !src_r[`BIT_CHARGER_SOURCE_MASK])
                     || (i_flash_irq && !src_r[`BIT_FLASH_SOURCE_MASK])
                     || (i_backlight_irq && !src_r[`BIT_BACKLIGHT_SOURCE_MASK]);

    // write decode, read clear and set; a set in the read cycle survives
    always_comb begin
        src_nxt = src_r;
        tmask_nxt = tmask_r;
        flags_nxt = flags_r;
        stat_nxt = {4'h0, above_s, mrst_s, upper_s, lower_s};
        if (rd_stb && sel_r && ptr_r == `OFS_TOP_IRQ_FLAGS) begin
            flags_nxt = 8'h00;
        end
        if (wr_stb && sel_r && ptr_r == `OFS_SOURCE_IRQ_MASK) begin
            src_nxt = shift_byte;
        end
        if (wr_stb && sel_r && ptr_r == `OFS_TOP_IRQ_MASK) begin
            tmask_nxt = shift_byte;
        end
        flags_nxt = flags_nxt | set_vec;
        irq_n_nxt = !pending;
    end

    always_ff @(posedge i_clk) begin
        if (por_rst) begin
            src_r <= `RST_SOURCE_IRQ_MASK;
            tmask_r <= `RST_TOP_IRQ_MASK;
            flags_r <= `RST_TOP_IRQ_FLAGS;
            irq_n_r <= 1'b1;
        end else begin
            src_r <= src_nxt;
            tmask_r <= tmask_nxt;
            flags_r <= flags_nxt;
            irq_n_r <= irq_n_nxt;
        end
        if (gen_rst) begin
            stat_r <= `RST_TOP_LIVE_STATUS;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign o_sda = 1'b0;  // open drain: only ever pulls low
    assign o_sda_oe_n = oe_n_r;
    assign o_irq_n = irq_n_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    addr_match_a: assert property (state_r == ST_ADDR && scl_rise && cnt_r == 4'h7 && !start
        && (hit_main || hit_bl) |=> ack_r ##[1:8] !oe_n_r) else $error("matched address not acked");
    addr_miss_a: assert property (state_r == ST_ADDR && scl_rise && cnt_r == 4'h7
        && !hit_main && !hit_bl |=> state_r == ST_SKIP && !ack_r) else $error("bad address acked");
    dir_select_a: assert property (state_r == ST_ADDR && scl_rise && cnt_r == 4'h7
        && hit_main |=> state_r == (shift_byte[0] ? ST_RDATA : ST_REG)) else $error("bad direction");
    por_masks_a: assert property (por_s |=> src_r == 8'hff && tmask_r == 8'hff
        && flags_r == 8'h00) else $error("power-on class not reset");
    gen_status_a: assert property (gen_rst |=> stat_r == 8'h00)
        else $error("status not reset");
    lower_flag_a: assert property (rise[3] && !por_rst |=> flags_r[0])
        else $error("lower die-hot flag missed");
    upper_flag_a: assert property (rise[4] && !por_rst |=> flags_r[1])
        else $error("upper die-hot flag missed");
    flag_clear_a: assert property (rd_stb && sel_r && ptr_r == 8'h24 && set_vec == 8'h00
        && !por_rst |=> flags_r == 8'h00) else $error("flags not cleared on read");
    supply_flag_a: assert property (fall[5] && !por_rst |=> flags_r[3])
        else $error("supply low flag missed");
    mask_write_a: assert property (wr_stb && sel_r && ptr_r == 8'h26 && !por_rst
        |=> tmask_r == $past(shift_byte)) else $error("top mask not written");
    pin_live_a: assert property (!gen_rst |=> stat_r[3] == $past(above_s)
        && stat_r[2] == $past(mrst_s)) else $error("live status wrong");
    irq_out_a: assert property (flags_r[0] && !tmask_r[0] && !src_r[1] && !por_rst
        |=> !o_irq_n) else $error("interrupt not raised");
    id_read_a: assert property (rd_stb && sel_r && ptr_r == 8'h20 |=> tx_r == ID_CODE)
        else $error("identity code wrong");
endmodule

// [include/top_irq_cfg.svh]
/*
 * Offsets, field positions, reset values and bus addresses of the top-level
 * interrupt and status register group.
 * Assumes nothing; definitions only, included by bare name.
 */
`ifndef TOP_IRQ_CFG_SVH
`define TOP_IRQ_CFG_SVH

// ****************************************************************
// serial bus slave addresses (write form, lsb is direction)
// ****************************************************************
`define ADDR_MAIN_WR 8'hcc
`define ADDR_BACKLIGHT_WR 8'h90

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CHIP_IDENTITY 8'h20
`define OFS_CHIP_REVISION 8'h21
`define OFS_SOURCE_IRQ_MASK 8'h23
`define OFS_TOP_IRQ_FLAGS 8'h24
`define OFS_TOP_IRQ_MASK 8'h26
`define OFS_TOP_LIVE_STATUS 8'h28

// ****************************************************************
// reset values
// ****************************************************************
`define RST_SOURCE_IRQ_MASK 8'hff
`define RST_TOP_IRQ_FLAGS 8'h00
`define RST_TOP_IRQ_MASK 8'hff
`define RST_TOP_LIVE_STATUS 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_CHARGER_SOURCE_MASK 0
`define BIT_TOP_SOURCE_MASK 1
`define BIT_FLASH_SOURCE_MASK 2
`define BIT_BACKLIGHT_SOURCE_MASK 4
`define BIT_DIE_HOT_LOWER 0
`define BIT_DIE_HOT_UPPER 1
`define BIT_MANUAL_RESET_PIN_LIVE 2
`define BIT_SUPPLY_LOW 3
`define TOP_FLAG_USED 8'h0b

// ****************************************************************
// bit counting on the serial link
// ****************************************************************
`define LAST_DATA_BIT 4'h7
`define ACK_BIT 4'h8

`endif

// [include/top_irq_pkg.sv]
/*
 * Types shared by the top-level interrupt register group.
 * Assumes nothing.
 */
package top_irq_pkg;
    // serial link transfer phase
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_RDATA,
        ST_SKIP
    } link_state_t;
endpackage

// [tb/host_bus_model.sv]
/*
 * Host-side model of the two-wire serial master: start, stop, byte send
 * and byte receive at a 125 ns bus clock period.
 * Assumes the bench resolves the data wire with a pull-up and feeds it back.
 */
`timescale 1ns/1ns
module host_bus_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // ********
    // bus idles released, clock stands high outside frames
    // ********
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // one bit: data changes mid-low, sampled mid-way through the high phase
    task automatic bit_cycle(input logic b, output logic got);
        #31 o_sda_low = !b;
        #31 o_scl = 1'b1;
        #31 got = i_sda;
        #32 o_scl = 1'b0;
    endtask

    // works from idle and as repeated start after an ack bit
    task automatic start_cond();
        #31 o_sda_low = 1'b0;
        #31 o_scl = 1'b1;
        #31 o_sda_low = 1'b1;
        #32 o_scl = 1'b0;
    endtask

    task automatic stop_cond();
        #31 o_sda_low = 1'b1;
        #31 o_scl = 1'b1;
        #31 o_sda_low = 1'b0;
        #32;
    endtask

    // msb first, so an address byte ends with its direction bit
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], g);
        end
        bit_cycle(1'b1, ack);
    endtask

    // released line while the device drives; nack ends the read
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(nack, g);
    endtask
endmodule

// [tb/testbench.sv]
/*
 * Self-checking bench: a reference model of the register group is compared
 * with every bus read and with the interrupt pin.
 * Assumes the host bus model drives the bus clock and its data pull.
 */
`timescale 1ns/1ns
`include "top_irq_cfg.svh"
module testbench;
    localparam logic [7:0] ID_VAL = 8'h6b;  // arbitrary value
    localparam logic [7:0] REV_VAL = 8'h0e;  // arbitrary value
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic scl, host_low, sda_line, o_sda, o_sda_oe_n, o_irq_n, ack;
    logic mr_n = 1'b1;
    logic die_lo = 1'b0;
    logic die_hi = 1'b0;
    logic sup_ok = 1'b1;
    logic por = 1'b0;
    logic lockout = 1'b0;
    logic chip_on = 1'b1;
    logic [2:0] src_irq = 3'h0;
    logic [7:0] ref_src = 8'hff;
    logic [7:0] ref_tmask = 8'hff;
    logic [7:0] ref_flags = 8'h00;
    logic [7:0] rnd;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    // ********
    // clock, wire and instances
    // ********
    always #5 i_clk = ~i_clk;
    // open-drain data wire with pull-up
    assign sda_line = (host_low || (!o_sda_oe_n && !o_sda)) ? 1'b0 : 1'b1;

    top_irq_regs #(.ID_CODE(ID_VAL), .REV_CODE(REV_VAL)) top_irq_regs_inst (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line),
        .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_manual_reset_n(mr_n),
        .i_die_over_lower(die_lo), .i_die_over_upper(die_hi),
        .i_supply_above_threshold(sup_ok), .i_supply_below_por(por),
        .i_undervoltage_lockout(lockout), .i_chip_on(chip_on),
        .i_charger_irq(src_irq[0]), .i_flash_irq(src_irq[1]),
        .i_backlight_irq(src_irq[2]), .o_irq_n(o_irq_n)
    );
    host_bus_model host_bus_model_inst (.i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low));

    // ********
    // reference model
    // ********
    function automatic logic [7:0] ref_read(input logic [7:0] ofs);
        case (ofs)
            `OFS_CHIP_IDENTITY: return ID_VAL;
            `OFS_CHIP_REVISION: return REV_VAL;
            `OFS_SOURCE_IRQ_MASK: return ref_src;
            `OFS_TOP_IRQ_FLAGS: return ref_flags;
            `OFS_TOP_IRQ_MASK: return ref_tmask;
            `OFS_TOP_LIVE_STATUS: begin
                if (!mr_n || lockout || por) return 8'h00;
                return {4'h0, sup_ok, mr_n, die_hi, die_lo};
            end
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic ref_irq_n();
        logic top;
        top = ((ref_flags & ~ref_tmask & 8'h0b) != 8'h00) && !ref_src[1];
        return !(top || (src_irq[0] && !ref_src[0]) || (src_irq[1] && !ref_src[2])
                 || (src_irq[2] && !ref_src[4]));
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_irq();
        check({7'h00, o_irq_n}, {7'h00, ref_irq_n()});
    endtask

    // pins change just after an edge; flag model follows their edges
    task automatic set_pins(input logic m, dl, dh, so, u, p);
        @(posedge i_clk);
        #1;
        if (dl && !die_lo) ref_flags[0] = 1'b1;
        if (dh && !die_hi) ref_flags[1] = 1'b1;
        if (!so && sup_ok) ref_flags[3] = 1'b1;
        if (p) begin
            ref_src = 8'hff;
            ref_tmask = 8'hff;
            ref_flags = 8'h00;
        end
        {mr_n, die_lo, die_hi, sup_ok, lockout, por} = {m, dl, dh, so, u, p};
        repeat (10) @(posedge i_clk);
    endtask

    task automatic ev(input int k, input logic v);
        set_pins(mr_n, (k == 0) ? v : die_lo, (k == 1) ? v : die_hi,
                 (k == 2) ? !v : sup_ok, lockout, por);
    endtask

    // ********
    // bus transfers
    // ********
    task automatic send(input logic [7:0] d, input logic exp_ack);
        host_bus_model_inst.send_byte(d, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host_bus_model_inst.start_cond();
        send(`ADDR_MAIN_WR, 1'b0);
        send(ofs, 1'b0);
        send(d, 1'b0);
        host_bus_model_inst.stop_cond();
        if (ofs == `OFS_SOURCE_IRQ_MASK) ref_src = d;
        if (ofs == `OFS_TOP_IRQ_MASK) ref_tmask = d;
    endtask

    task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, output logic [7:0] d);
        host_bus_model_inst.start_cond();
        send(dev, 1'b0);
        send(ofs, 1'b0);
        host_bus_model_inst.start_cond();
        send(dev | 8'h01, 1'b0);
        host_bus_model_inst.recv_byte(1'b1, d);
        host_bus_model_inst.stop_cond();
    endtask

    // a flag read empties the model's flags, as the device clears on read
    task automatic rd_chk(input logic [7:0] ofs);
        logic [7:0] d;
        rd(`ADDR_MAIN_WR, ofs, d);
        check(d, ref_read(ofs));
        if (ofs == `OFS_TOP_IRQ_FLAGS) ref_flags = 8'h00;
    endtask

    task automatic end_of_test();
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard: the sequence needs roughly a third of this
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ********
    // main sequence
    // ********
    initial begin
        rnd = 8'($urandom(97322));
        repeat (16) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        repeat (8) @(posedge i_clk);
        rd_chk(`OFS_SOURCE_IRQ_MASK);
        rd_chk(`OFS_TOP_IRQ_FLAGS);
        rd_chk(`OFS_TOP_IRQ_MASK);
        rd_chk(`OFS_TOP_LIVE_STATUS);
        wr(`OFS_CHIP_IDENTITY, ~ID_VAL);
        wr(`OFS_CHIP_REVISION, ~REV_VAL);
        rd_chk(`OFS_CHIP_IDENTITY);
        rd_chk(`OFS_CHIP_REVISION);
        rnd = 8'($urandom);
        wr(`OFS_SOURCE_IRQ_MASK, rnd);
        rd_chk(`OFS_SOURCE_IRQ_MASK);
        wr(`OFS_TOP_IRQ_MASK, ~rnd);
        rd_chk(`OFS_TOP_IRQ_MASK);
        // each top event: masked, unmasked, source-masked, then read clear
        wr(`OFS_SOURCE_IRQ_MASK, 8'hfd);
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_TOP_IRQ_MASK, 8'hff);
            ev(k, 1'b1);
            chk_irq();
            wr(`OFS_TOP_IRQ_MASK, ~(8'h01 << ((k == 2) ? 3 : k)));
            chk_irq();
            wr(`OFS_SOURCE_IRQ_MASK, 8'hff);
            chk_irq();
            wr(`OFS_SOURCE_IRQ_MASK, 8'hfd);
            rd_chk(`OFS_TOP_IRQ_FLAGS);
            chk_irq();
            rd_chk(`OFS_TOP_IRQ_FLAGS);
            ev(k, 1'b0);
        end
        // function summaries through their own source mask bits
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_SOURCE_IRQ_MASK, ~(8'h01 << (2 * k)));
            @(posedge i_clk);
            #1;
            src_irq[k] = 1'b1;
            repeat (4) @(posedge i_clk);
            chk_irq();
            wr(`OFS_SOURCE_IRQ_MASK, 8'hff);
            chk_irq();
            @(posedge i_clk);
            #1;
            src_irq[k] = 1'b0;
        end
        // random pin levels, including manual reset and lockout
        for (int n = 0; n < 8; n++) begin
            rnd = 8'($urandom);
            set_pins(rnd[0] | rnd[5], rnd[1], rnd[2], rnd[3], rnd[4] & rnd[6], 1'b0);
            rd_chk(`OFS_TOP_LIVE_STATUS);
            rd_chk(`OFS_TOP_IRQ_FLAGS);
        end
        set_pins(1'b0, die_lo, die_hi, 1'b1, 1'b1, 1'b0);
        rd_chk(`OFS_TOP_LIVE_STATUS);
        set_pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        @(posedge i_clk);
        #1;
        chip_on = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        chip_on = 1'b1;
        repeat (8) @(posedge i_clk);
        rd_chk(`OFS_TOP_LIVE_STATUS);
        // unknown address refused, backlight address answered
        host_bus_model_inst.start_cond();
        send(8'h50, 1'b1);
        host_bus_model_inst.stop_cond();
        rd(`ADDR_BACKLIGHT_WR, 8'h98, rnd);
        check(rnd, 8'h00);
        // burst read: master acks the first byte, pointer steps to the next
        host_bus_model_inst.start_cond();
        send(`ADDR_MAIN_WR, 1'b0);
        send(`OFS_CHIP_IDENTITY, 1'b0);
        host_bus_model_inst.start_cond();
        send(`ADDR_MAIN_WR | 8'h01, 1'b0);
        host_bus_model_inst.recv_byte(1'b0, rnd);
        check(rnd, ID_VAL);
        host_bus_model_inst.recv_byte(1'b1, rnd);
        check(rnd, REV_VAL);
        host_bus_model_inst.stop_cond();
        // power-on class returns to defaults
        wr(`OFS_SOURCE_IRQ_MASK, 8'h00);
        wr(`OFS_TOP_IRQ_MASK, 8'h00);
        set_pins(mr_n, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        set_pins(mr_n, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        set_pins(mr_n, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd_chk(`OFS_SOURCE_IRQ_MASK);
        rd_chk(`OFS_TOP_IRQ_MASK);
        rd_chk(`OFS_TOP_IRQ_FLAGS);
        end_of_test();
    end
endmodule
